// File: verilog/pmc_map.svh
// Register offsets, field positions, reset values and counts of the power mode controller.
// Assumes a 12-bit APB byte address; every register is one aligned 32-bit word.
`ifndef PMC_MAP_SVH
`define PMC_MAP_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define PMC_OFS_CPU_DIV      12'h000
`define PMC_OFS_FREQ_OUT     12'h004
`define PMC_OFS_PERIPH_DIS   12'h008
`define PMC_OFS_RTC_CTRL     12'h00C
`define PMC_OFS_RTC_PERIOD   12'h010
`define PMC_OFS_RTC_COUNT    12'h014
`define PMC_OFS_STATUS       12'h018

// ****************************************************************
// Field positions
// ****************************************************************
`define PMC_PROGRAMMABLE_FREQ_OUTPUT_EN_BIT      31
`define PMC_PROGRAMMABLE_FREQ_OUTPUT_RELOAD_MSB  15
`define PMC_RTC_LP_BIT       0
`define PMC_RTC_WAKE_BIT     1
`define PMC_DIV_MSB          7
`define PMC_PDIS_MSB         7
`define PMC_STATUS_MODE_MSB  1

// ****************************************************************
// Reset values and counts
// ****************************************************************
`define PMC_RST_CPU_DIV      8'h00
`define PMC_RST_PROGRAMMABLE_FREQ_OUTPUT_RELOAD  16'h0000
`define PMC_RST_PERIPH_DIS   8'h00
`define PMC_RTC_PRESCALE     32
`define PMC_RTC_PRE_LAST     5'h1F
`define PMC_ZERO32           32'h0000_0000

`endif

// File: verilog/pmc_pkg.sv
// Types shared by the power mode controller: APB carriers, modes and state records.
// Assumes pmc_map.svh is included wherever offsets are needed.
package pmc_pkg;

  // ****************************************************************
  // Bus carriers
  // ****************************************************************
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } pmc_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } pmc_apb_rsp_t;

  // ****************************************************************
  // Power modes
  // ****************************************************************
  typedef enum logic [1:0] {
    PMC_ACTIVE,
    PMC_IDLE,
    PMC_SLEEP,
    PMC_PDOWN
  } pmc_mode_t;

  // ****************************************************************
  // Cpu side power instructions, one-cycle pulses
  // ****************************************************************
  typedef struct packed {
    logic idle;
    logic sleep;
    logic pdown;
  } pmc_instr_t;

  // ****************************************************************
  // State records
  // ****************************************************************
  typedef struct packed {
    pmc_mode_t   mode;
    logic [7:0]  cpu_div;
    logic [7:0]  div_cnt;
    logic        programmable_freq_output_en;
    logic [15:0] programmable_freq_output_reload;
    logic [15:0] programmable_freq_output_cnt;
    logic        programmable_freq_output_lvl;
    logic [7:0]  periph_dis;
    logic        rtc_lp;
    logic        wake_en;
    logic [31:0] prdata;
    logic        pslverr;
    logic        irq_s1;
    logic        irq_s2;
  } pmc_state_t;

  typedef struct packed {
    logic [4:0]  pre;
    logic [31:0] count;
    logic [15:0] period;
    logic [15:0] per_cnt;
    logic        wake;
  } pmc_rtc_t;

endpackage

// File: verilog/pmc_top.sv
// Power mode controller: power-save modes, cpu clock divider, frequency output,
// per-peripheral clock gating and a reset-proof real time clock with wake-ups.
// Assumes a cpu core on clk_i that pulses the power instructions and an APB master.
//
// Functional notes
// - Power modes are entered only by cpu instruction pulses.
// - Idle halts the cpu clock; enabled peripherals keep their clocks.
// - Sleep and power down stop cpu and every peripheral clock.
// - Optionally the real time clock keeps counting in sleep and power down.
// - An active external interrupt ends sleep.
// - Clocks of inactive peripherals are gated off automatically.
// - Software programs a cpu clock divider; cpu runs at the reduced rate.
// - An output pin carries a clock whose frequency software programs.
// - A disable register stops a peripheral clock until re-enabled.
// - Each peripheral has its own enable bit, independent of others.
// - The real time clock issues periodic wake-ups ending low-power phases.
// - The real time clock ticks at the system clock divided by 32.
// - Real time clock registers are untouched by any reset; the code resets the control bits rtc_lp and wake_en to 0.
//
// Added by the designer: the address map and the APB register port.
`include "pmc_map.svh"
`timescale 1ns/100ps
`default_nettype none

module pmc_top
  import pmc_pkg::*;
(
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire pmc_apb_req_t apb_i,
  output pmc_apb_rsp_t      apb_o,
  input  wire pmc_instr_t   instr_i,
  input  wire logic         ext_irq_i,
  input  wire logic         periph_irq_i,
  input  wire logic [7:0]   periph_active_i,
  output logic              cpu_clk_en_o,
  output logic [7:0]        periph_clk_en_o,
  output logic              freq_out_o,
  output logic              rtc_wake_o,
  output pmc_mode_t         mode_o
);

  // ****************************************************************
  // Reset release
  // ****************************************************************
  // Asserts at once; lifts on an edge so all flops leave reset together
  logic rst_s1;
  logic rst_n;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // ****************************************************************
  // Declarations
  // ****************************************************************
  pmc_state_t  s;
  pmc_state_t  next_s;
  pmc_rtc_t    rtc;
  pmc_rtc_t    next_rtc;
  logic        setup;
  logic        wr_access;
  logic        low_power;
  logic        rtc_run;
  logic        rtc_tick;
  logic [31:0] rd_value;
  logic        rd_hit;

  // Address decode and write strobes
  logic        sel_cpu_div;
  logic        sel_freq_out;
  logic        sel_periph_dis;
  logic        sel_rtc_ctrl;
  logic        sel_rtc_period;
  logic        sel_rtc_count;
  logic        sel_status;
  logic        we_rtc_period;
  logic        we_rtc_count;

  // Mode flags and wake sources
  logic        in_active;
  logic        in_sleep;
  logic        in_pdown;
  logic        idle_wake;
  logic        pdown_wake;

  // Counter wrap points
  logic        div_wrap;
  logic        programmable_freq_output_wrap;
  logic        rtc_period_end;

  assign setup     = apb_i.psel && !apb_i.penable;
  assign wr_access = apb_i.psel && apb_i.penable && apb_i.pwrite;
  assign in_active = (s.mode == PMC_ACTIVE);
  assign in_sleep  = (s.mode == PMC_SLEEP);
  assign in_pdown  = (s.mode == PMC_PDOWN);
  assign low_power = in_sleep || in_pdown;

  // Oscillator prescale runs whatever the cpu divider says
  assign rtc_tick  = (rtc.pre == `PMC_RTC_PRE_LAST);
  // Stopped in deep modes unless software asked it to keep time
  assign rtc_run   = !low_power || s.rtc_lp;

  // ****************************************************************
  // Counter wraps
  // ****************************************************************
  assign div_wrap       = (s.div_cnt >= s.cpu_div);
  assign programmable_freq_output_wrap      = (s.programmable_freq_output_cnt >= s.programmable_freq_output_reload);
  assign rtc_period_end = (rtc.per_cnt >= rtc.period);

  // ****************************************************************
  // Wake sources
  // ****************************************************************
  assign idle_wake  = periph_irq_i || s.irq_s2 || rtc.wake;
  // Power down listens to the clock wake-up alone
  assign pdown_wake = rtc.wake;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  always_comb begin
    sel_cpu_div    = 1'b0;
    sel_freq_out   = 1'b0;
    sel_periph_dis = 1'b0;
    sel_rtc_ctrl   = 1'b0;
    sel_rtc_period = 1'b0;
    sel_rtc_count  = 1'b0;
    sel_status     = 1'b0;
    // Status is read-only: a write to it is dropped without an error
    if (apb_i.paddr == `PMC_OFS_CPU_DIV) begin
      sel_cpu_div = 1'b1;
    end else if (apb_i.paddr == `PMC_OFS_FREQ_OUT) begin
      sel_freq_out = 1'b1;
    end else if (apb_i.paddr == `PMC_OFS_PERIPH_DIS) begin
      sel_periph_dis = 1'b1;
    end else if (apb_i.paddr == `PMC_OFS_RTC_CTRL) begin
      sel_rtc_ctrl = 1'b1;
    end else if (apb_i.paddr == `PMC_OFS_RTC_PERIOD) begin
      sel_rtc_period = 1'b1;
    end else if (apb_i.paddr == `PMC_OFS_RTC_COUNT) begin
      sel_rtc_count = 1'b1;
    end else if (apb_i.paddr == `PMC_OFS_STATUS) begin
      sel_status = 1'b1;
    end
  end

  // Writes land in the access phase, the edge at which pready is sampled
  assign we_rtc_period = wr_access && sel_rtc_period;
  assign we_rtc_count  = wr_access && sel_rtc_count;

  // ****************************************************************
  // Read decode
  // ****************************************************************
  always_comb begin
    rd_value = `PMC_ZERO32;
    rd_hit   = 1'b1;
    if (sel_cpu_div) begin
      rd_value[`PMC_DIV_MSB:0] = s.cpu_div;
    end else if (sel_freq_out) begin
      rd_value[`PMC_PROGRAMMABLE_FREQ_OUTPUT_EN_BIT]         = s.programmable_freq_output_en;
      rd_value[`PMC_PROGRAMMABLE_FREQ_OUTPUT_RELOAD_MSB:0]   = s.programmable_freq_output_reload;
    end else if (sel_periph_dis) begin
      rd_value[`PMC_PDIS_MSB:0] = s.periph_dis;
    end else if (sel_rtc_ctrl) begin
      rd_value[`PMC_RTC_LP_BIT]   = s.rtc_lp;
      rd_value[`PMC_RTC_WAKE_BIT] = s.wake_en;
    end else if (sel_rtc_period) begin
      rd_value[`PMC_PROGRAMMABLE_FREQ_OUTPUT_RELOAD_MSB:0] = rtc.period;
    end else if (sel_rtc_count) begin
      rd_value = rtc.count;
    end else if (sel_status) begin
      rd_value[`PMC_STATUS_MODE_MSB:0] = s.mode;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // ****************************************************************
  // Main state
  // ****************************************************************
  always_comb begin
    next_s        = s;
    // Only the second synchroniser stage feeds the mode logic
    next_s.irq_s1 = ext_irq_i;
    next_s.irq_s2 = s.irq_s1;

    // Read data and error are captured in the setup phase so the access phase answers at once
    if (setup) begin
      next_s.prdata  = apb_i.pwrite ? `PMC_ZERO32 : rd_value;
      next_s.pslverr = !rd_hit;
    end

    if (wr_access) begin
      if (sel_cpu_div) begin
        next_s.cpu_div = apb_i.pwdata[`PMC_DIV_MSB:0];
      end else if (sel_freq_out) begin
        next_s.programmable_freq_output_en     = apb_i.pwdata[`PMC_PROGRAMMABLE_FREQ_OUTPUT_EN_BIT];
        next_s.programmable_freq_output_reload = apb_i.pwdata[`PMC_PROGRAMMABLE_FREQ_OUTPUT_RELOAD_MSB:0];
      end else if (sel_periph_dis) begin
        next_s.periph_dis = apb_i.pwdata[`PMC_PDIS_MSB:0];
      end else if (sel_rtc_ctrl) begin
        next_s.rtc_lp  = apb_i.pwdata[`PMC_RTC_LP_BIT];
        next_s.wake_en = apb_i.pwdata[`PMC_RTC_WAKE_BIT];
      end
    end

    // Cpu clock divider; counter holds while the cpu is halted
    if (in_active) begin
      next_s.div_cnt = div_wrap ? 8'h00 : s.div_cnt + 8'h01;
    end

    // Frequency output stops with every other clock in the deep modes
    // A reload of n toggles the pin every n+1 cycles
    if (!s.programmable_freq_output_en || low_power) begin
      next_s.programmable_freq_output_cnt = `PMC_RST_PROGRAMMABLE_FREQ_OUTPUT_RELOAD;
    end else if (programmable_freq_output_wrap) begin
      next_s.programmable_freq_output_cnt = `PMC_RST_PROGRAMMABLE_FREQ_OUTPUT_RELOAD;
      next_s.programmable_freq_output_lvl = !s.programmable_freq_output_lvl;
    end else begin
      next_s.programmable_freq_output_cnt = s.programmable_freq_output_cnt + 16'h0001;
    end

    // Mode sequencing
    case (s.mode)
      PMC_ACTIVE: begin
        // Only instruction pulses move the mode; no register does
        if (instr_i.pdown) begin
          next_s.mode = PMC_PDOWN;
        end else if (instr_i.sleep) begin
          next_s.mode = PMC_SLEEP;
        end else if (instr_i.idle) begin
          next_s.mode = PMC_IDLE;
        end
      end
      PMC_IDLE: begin
        if (idle_wake) begin
          next_s.mode = PMC_ACTIVE;
        end
      end
      PMC_SLEEP: begin
        if (s.irq_s2) begin
          next_s.mode = PMC_ACTIVE;
        end else if (rtc.wake) begin
          next_s.mode = PMC_ACTIVE;
        end
      end
      PMC_PDOWN: begin
        // Interrupt pins are deliberately ignored here
        if (pdown_wake) begin
          next_s.mode = PMC_ACTIVE;
        end
      end
      default: begin
        next_s.mode = PMC_ACTIVE;
      end
    endcase
  end

  // ****************************************************************
  // State registers
  // ****************************************************************
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s             <= '0;
      s.mode        <= PMC_ACTIVE;
      s.cpu_div     <= `PMC_RST_CPU_DIV;
      s.programmable_freq_output_reload <= `PMC_RST_PROGRAMMABLE_FREQ_OUTPUT_RELOAD;
      s.periph_dis  <= `PMC_RST_PERIPH_DIS;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // Real time clock
  // ****************************************************************
  always_comb begin
    next_rtc      = rtc;
    next_rtc.wake = 1'b0;
    if (we_rtc_period) begin
      next_rtc.period = apb_i.pwdata[`PMC_PROGRAMMABLE_FREQ_OUTPUT_RELOAD_MSB:0];
    end
    if (we_rtc_count) begin
      next_rtc.count   = apb_i.pwdata;
      // Loading the count also starts the unreset prescale and period chain
      next_rtc.pre     = 5'h00;
      next_rtc.per_cnt = 16'h0000;
    end else if (rtc_run) begin
      next_rtc.pre = rtc.pre + 5'h01;
      if (rtc_tick) begin
        next_rtc.count = rtc.count + 32'h0000_0001;
        if (rtc_period_end) begin
          next_rtc.per_cnt = 16'h0000;
          next_rtc.wake    = s.wake_en;
        end else begin
          next_rtc.per_cnt = rtc.per_cnt + 16'h0001;
        end
      end
    end
  end

  // No reset: time must survive every reset, so values start unknown after power-up
  always_ff @(posedge clk_i) begin
    rtc <= next_rtc;
  end

  // ****************************************************************
  // Clock enables
  // ****************************************************************
  // Cpu halted in idle, sleep and power down
  assign cpu_clk_en_o = in_active && (s.div_cnt == 8'h00);

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_periph
      // One bit per peripheral; inactive ones lose their clock without software
      assign periph_clk_en_o[gi] = !low_power && !s.periph_dis[gi] && periph_active_i[gi];
    end
  endgenerate

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign freq_out_o     = s.programmable_freq_output_lvl;
  assign rtc_wake_o     = rtc.wake;
  assign mode_o         = s.mode;

  // ****************************************************************
  // Bus response
  // ****************************************************************
  // Zero wait states: every access phase completes at once
  assign apb_o.pready   = 1'b1;
  assign apb_o.prdata   = s.prdata;
  assign apb_o.pslverr  = s.pslverr && apb_i.psel && apb_i.penable;

endmodule // pmc_top

`default_nettype wire

// File: tb/pmc_cpu_model.sv
// Cpu core model: turns a bench request into one power instruction pulse.
// Assumes the controller's clock; op 1 idle, 2 sleep, 3 power down.
`timescale 1ns/100ps
`default_nettype none

module pmc_cpu_model
  import pmc_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic [1:0] op_i,
  output pmc_instr_t      instr_o
);
  // Registered, so the pulse is one cycle late and lasts as many cycles as op_i is held
  always_ff @(posedge clk_i) begin
    instr_o <= '{idle: op_i == 2'h1, sleep: op_i == 2'h2, pdown: op_i == 2'h3};
  end
endmodule // pmc_cpu_model

`default_nettype wire

// File: tb/pmc_asserts.sv
// Port checker of the power mode controller.
// Assumes binding to pmc_top; one clock domain.
`timescale 1ns/100ps
`default_nettype none

module pmc_asserts
  import pmc_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  input wire pmc_instr_t instr_i,
  input wire logic       ext_irq_i,
  input wire logic [7:0] periph_active_i,
  input wire logic       cpu_clk_en_o,
  input wire logic [7:0] periph_clk_en_o,
  input wire logic       freq_out_o,
  input wire logic       rtc_wake_o,
  input wire pmc_mode_t  mode_o
);
  // ****
  // Properties
  // ****
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic deep;
  assign deep = mode_o == PMC_SLEEP || mode_o == PMC_PDOWN;

  a_only_by_instr: assert property (mode_o == PMC_ACTIVE && instr_i == '0 |=> mode_o == PMC_ACTIVE)
    else $error("mode left active without instruction");
  a_sleep_entry: assert property (mode_o == PMC_ACTIVE && instr_i.sleep && !instr_i.pdown |=> mode_o == PMC_SLEEP)
    else $error("sleep instruction not taken");
  a_idle_cpu_halt: assert property (mode_o == PMC_IDLE |-> !cpu_clk_en_o)
    else $error("cpu clock runs in idle");
  a_deep_clk_off: assert property (deep |-> !cpu_clk_en_o && periph_clk_en_o == 8'h00)
    else $error("clock enabled in deep mode");
  a_programmable_freq_output_frozen: assert property (deep |=> $stable(freq_out_o))
    else $error("frequency output moved in deep mode");
  a_gate_inactive: assert property ((periph_clk_en_o & ~periph_active_i) == 8'h00)
    else $error("clock given to inactive peripheral");
  a_sleep_irq_wake: assert property (mode_o == PMC_SLEEP && ext_irq_i |-> ##[1:4] mode_o == PMC_ACTIVE)
    else $error("external interrupt did not end sleep");
  a_pdown_holds: assert property (mode_o == PMC_PDOWN && !rtc_wake_o |=> mode_o == PMC_PDOWN)
    else $error("power down left without wake-up");
  a_rtc_wake_exit: assert property (rtc_wake_o && deep |=> mode_o == PMC_ACTIVE)
    else $error("wake-up did not end deep mode");
  a_wake_pulse: assert property (rtc_wake_o |=> !rtc_wake_o)
    else $error("wake-up longer than one cycle");
endmodule // pmc_asserts

bind pmc_top pmc_asserts i_pmc_asserts (.clk_i(clk_i), .rst_n_i(rst_n_i), .instr_i(instr_i),
  .ext_irq_i(ext_irq_i), .periph_active_i(periph_active_i), .cpu_clk_en_o(cpu_clk_en_o),
  .periph_clk_en_o(periph_clk_en_o), .freq_out_o(freq_out_o), .rtc_wake_o(rtc_wake_o), .mode_o(mode_o));

`default_nettype wire

// File: tb/tb.sv
// Self-checking bench of the power mode controller.
// Assumes pmc_top with its bound checker and the cpu model.
`include "pmc_map.svh"
`timescale 1ns/100ps
`default_nettype none

module tb;
  import pmc_pkg::*;
  logic         clk = 1'b0;
  logic         rst_n = 1'b0;
  pmc_apb_req_t apb = '0;
  pmc_apb_rsp_t rsp;
  logic [1:0]   op = 2'h0;
  pmc_instr_t   instr;
  logic         ext_irq = 1'b0;
  logic         pirq = 1'b0;
  logic [7:0]   act = 8'h00;
  logic         cpu_en, programmable_freq_output, wake, prev;
  logic [7:0]   pen;
  pmc_mode_t    mode;
  logic [32:0]  expq [$];
  logic [31:0]  seed = 32'hFABA;
  logic [31:0]  got, g1, d;
  logic [11:0]  ofs [5] = '{`PMC_OFS_CPU_DIV, `PMC_OFS_FREQ_OUT, `PMC_OFS_PERIPH_DIS, `PMC_OFS_STATUS, 12'h01C};
  int           n_errors = 0;
  int           n_compared = 0;
  int           n;

  always #2.5 clk = ~clk;

  pmc_cpu_model i_pmc_cpu_model (.clk_i(clk), .op_i(op), .instr_o(instr));
  pmc_top i_pmc_top (.clk_i(clk), .rst_n_i(rst_n), .apb_i(apb), .apb_o(rsp), .instr_i(instr),
    .ext_irq_i(ext_irq), .periph_irq_i(pirq), .periph_active_i(act), .cpu_clk_en_o(cpu_en),
    .periph_clk_en_o(pen), .freq_out_o(programmable_freq_output), .rtc_wake_o(wake), .mode_o(mode));

  // ****
  // Helpers
  // ****
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [32:0] g, input logic [32:0] e);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask

  // Read results are compared here, oldest note first
  always @(posedge clk) begin
    if (apb.psel && apb.penable && rsp.pready === 1'b1 && !apb.pwrite && expq.size() > 0) begin
      chk({rsp.pslverr, rsp.prdata}, expq.pop_front());
    end
  end

  // Called just after a rising edge; holds the request until pready
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
    @(posedge clk);
    apb.penable <= 1'b1;
    @(posedge clk);
    while (rsp.pready !== 1'b1) @(posedge clk);
    got = rsp.prdata;
    apb <= '0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    expq.push_back(e);
    xfer(1'b0, a, 32'h0000_0000);
  endtask

  // Issue one instruction, then stop mid-cycle once the mode has moved
  task automatic cpu(input logic [1:0] o);
    op <= o;
    @(posedge clk);
    op <= 2'h0;
    repeat (2) @(negedge clk);
  endtask

  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #50000;
    n_errors++;
    tally_and_finish();
  end

  // ****
  // Tests
  // ****
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    foreach (ofs[i]) rd(ofs[i], {ofs[i] == 12'h01C, 32'h0000_0000});
    xfer(1'b1, `PMC_OFS_STATUS, 32'h0000_0003);
    chk(mode, PMC_ACTIVE);
    $display("register test done");
    repeat (4) begin
      got = rnd();
      act <= got[7:0];
      d = rnd();
      xfer(1'b1, `PMC_OFS_PERIPH_DIS, d);
      @(negedge clk);
      chk(pen, act & ~d[7:0]);
      @(posedge clk);
    end
    xfer(1'b1, `PMC_OFS_PERIPH_DIS, 32'h0000_0000);
    @(negedge clk);
    chk(pen, act);
    $display("peripheral gating test done");
    @(posedge clk);
    xfer(1'b1, `PMC_OFS_CPU_DIV, 32'h0000_0003);
    n = 0;
    repeat (40) begin
      @(negedge clk);
      n += cpu_en;
    end
    chk(n, 10);
    @(posedge clk);
    xfer(1'b1, `PMC_OFS_CPU_DIV, 32'h0000_0000);
    xfer(1'b1, `PMC_OFS_FREQ_OUT, 32'h8000_0004);
    repeat (10) @(negedge clk);
    n = 0;
    repeat (100) begin
      prev = programmable_freq_output;
      @(negedge clk);
      n += (programmable_freq_output !== prev);
    end
    chk(n, 20);
    $display("clock rate test done");
    @(posedge clk);
    act <= 8'h5A;
    cpu(2'h1);
    chk({cpu_en, pen, mode}, {1'b0, 8'h5A, PMC_IDLE});
    @(posedge clk);
    pirq <= 1'b1;
    @(posedge clk);
    pirq <= 1'b0;
    @(negedge clk);
    chk(mode, PMC_ACTIVE);
    @(posedge clk);
    cpu(2'h2);
    chk({cpu_en, pen, mode}, {1'b0, 8'h00, PMC_SLEEP});
    @(posedge clk);
    cpu(2'h1);
    chk(mode, PMC_SLEEP);
    @(posedge clk);
    ext_irq <= 1'b1;
    repeat (4) @(posedge clk);
    ext_irq <= 1'b0;
    @(negedge clk);
    chk(mode, PMC_ACTIVE);
    $display("idle and sleep test done");
    @(posedge clk);
    xfer(1'b1, `PMC_OFS_RTC_COUNT, 32'h0000_0000);
    xfer(1'b1, `PMC_OFS_RTC_PERIOD, 32'h0000_0003);
    xfer(1'b1, `PMC_OFS_RTC_CTRL, 32'h0000_0003);
    cpu(2'h3);
    @(posedge clk);
    ext_irq <= 1'b1;
    repeat (10) @(posedge clk);
    ext_irq <= 1'b0;
    @(negedge clk);
    chk(mode, PMC_PDOWN);
    n = 0;
    while (mode !== PMC_ACTIVE && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk(mode, PMC_ACTIVE);
    n = 0;
    while (wake !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (wake !== 1'b1 && n < 300);
    chk(n, 128);
    $display("power down test done");
    @(posedge clk);
    xfer(1'b0, `PMC_OFS_RTC_COUNT, 32'h0000_0000);
    g1 = got;
    repeat (61) @(posedge clk);
    xfer(1'b0, `PMC_OFS_RTC_COUNT, 32'h0000_0000);
    chk(got - g1, 2);
    g1 = got;
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    xfer(1'b0, `PMC_OFS_RTC_COUNT, 32'h0000_0000);
    chk(got - g1 < 32'h0000_0002, 1);
    $display("real time clock test done");
    tally_and_finish();
  end
endmodule // tb

`default_nettype wire
